// >>> hw/cond_sysctl_pkg.sv
`default_nettype none
package cond_sysctl_pkg;
  // ----------------
  // Operation classes
  // ----------------
  typedef enum logic [4:0] {
    OP_NONE, OP_BRANCH, OP_SETCOND, OP_DECBRANCH, OP_COND_TRAP, OP_OVF_TRAP,
    OP_BOUND_TEST, OP_DUAL_BOUND, OP_BRK_POINT, OP_DEBUG_ENTRY, OP_STOP,
    OP_LP_HALT, OP_FLAG_AND, OP_FLAG_XOR, OP_FLAG_OR, OP_FLAG_MOVE_IN,
    OP_FLAG_MOVE_OUT, OP_PSW_AND, OP_PSW_XOR, OP_PSW_OR, OP_PSW_MOVE_IN,
    OP_PSW_MOVE_OUT, OP_ALT_MOVE, OP_EXC_RETURN, OP_PRIV_OTHER
  } sysop_t;
  typedef enum logic [2:0] {
    EXC_NONE, EXC_COND_TRAP, EXC_OVF_TRAP, EXC_BOUND, EXC_ILLEGAL,
    EXC_DEBUG, EXC_PRIVILEGE, EXC_FORMAT
  } exc_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} opsize_t;
  typedef struct packed {
    sysop_t kind;
    logic [3:0] cond;
    logic [15:0] imm;
    logic [31:0] value;
    logic [31:0] lower;
    logic [31:0] upper;
    opsize_t size;
    logic altWrite;
  } op_req_t;
  // ----------------
  // Condition field codes
  // ----------------
  localparam logic [3:0] COND_TRUE = 4'h0;
  localparam logic [3:0] COND_FALSE = 4'h1;
  localparam logic [3:0] COND_HIGH = 4'h2;
  localparam logic [3:0] COND_LOW_OR_SAME = 4'h3;
  localparam logic [3:0] COND_CARRY_CLR = 4'h4;
  localparam logic [3:0] COND_CARRY_SET = 4'h5;
  localparam logic [3:0] COND_NOT_EQUAL = 4'h6;
  localparam logic [3:0] COND_EQUAL = 4'h7;
  localparam logic [3:0] COND_OVF_CLR = 4'h8;
  localparam logic [3:0] COND_OVF_SET = 4'h9;
  localparam logic [3:0] COND_PLUS = 4'hA;
  localparam logic [3:0] COND_MINUS = 4'hB;
  localparam logic [3:0] COND_GREATER_EQUAL = 4'hC;
  localparam logic [3:0] COND_LESS_THAN = 4'hD;
  localparam logic [3:0] COND_GREATER_THAN = 4'hE;
  localparam logic [3:0] COND_LESS_EQUAL = 4'hF;
  // ----------------
  // Processor state word layout
  // ----------------
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int PSW_SUPER = 13;
  localparam logic [15:0] PSW_RESET = 16'h2700;
  localparam logic [15:0] FLAG_BYTE_MASK = 16'h00FF;
  // ----------------
  // Exception return frame
  // ----------------
  localparam logic [31:0] RET_PC_HI_OFS = 32'h00000002;
  localparam logic [31:0] RET_PC_LO_OFS = 32'h00000004;
  localparam logic [31:0] RET_FMT_OFS = 32'h00000006;
  localparam logic [31:0] RET_SHORT_LEN = 32'h00000008;
  localparam logic [31:0] RET_LONG_LEN = 32'h0000000C;
  localparam logic [3:0] FMT_SHORT = 4'h0;
  localparam logic [3:0] FMT_LONG = 4'h2;
  // ----------------
  // Register port map
  // ----------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SRC_SPACE = 4'h1;
  localparam logic [3:0] REG_DST_SPACE = 4'h2;
  localparam logic [3:0] REG_PSW = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_DBG_EN = 0;
endpackage
`default_nettype wire

// >>> hw/condition_test_sysctl_unit.sv
// Contract
// - A condition test yields one for true, zero for false, from the flags.
// - Code 0000 is always true; code 0001 is always false.
// - Equal needs zero set; not equal needs zero clear.
// - Overflow clear and overflow set follow the overflow flag.
// - Greater-or-equal: negative equals overflow; less-than: they differ.
// - The always-false code is not a branch condition; plain branches flag it, decrement branches do not.
// - Privileged, trapping and flag-touching operations flush the pipeline.
// - Conditional trap uses the same tests and traps when true.
// - Overflow trap traps only when overflow is set.
// - Dual bound check traps when value is outside lower..upper bounds.
// - Breakpoint runs a cycle; acknowledge returns a word, else illegal trap.
// - Debug entry enters debug mode if enabled, else takes an exception.
// - Stop loads its immediate into the state word, then halts.
// - Flag byte AND, XOR, OR with an 8-bit immediate.
// - State word AND, XOR, OR with a 16-bit immediate.
// - Alternate move uses destination code on writes, source code on reads.
// - Return pops state word, then program counter, then frame by format.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module condition_test_sysctl_unit
  import cond_sysctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire op_req_t opReq,
  output logic opReady,
  input wire logic [31:0] stackPtr,
  output logic memReq,
  output logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic [15:0] memData,
  output logic bkptCycle,
  input wire logic bkptAckPin,
  input wire logic bkptErrPin,
  input wire logic [15:0] bkptWordPin,
  output logic bkptExec,
  output logic [15:0] bkptWord,
  input wire logic wakeIn,
  output logic condDone,
  output logic condResult,
  output logic branchAltCode,
  output logic flushPulse,
  output logic excValid,
  output exc_t excKind,
  output logic debugEnter,
  output logic halted,
  output logic lowPower,
  output logic spaceValid,
  output logic [2:0] spaceCode,
  output logic [15:0] psw,
  output logic spLoad,
  output logic [31:0] spOut,
  output logic pcLoad,
  output logic [31:0] pcOut,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData
);
  // ----------------
  // State
  // ----------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_HALT, ST_BRK_WAIT, ST_RET_SR, ST_RET_PC_HI, ST_RET_PC_LO, ST_RET_FMT
  } fsm_t;
  typedef struct packed {
    fsm_t fsm;
    exc_t excKind, lastExc;
    logic [15:0] psw, newPsw, bkptWord, wordS1, wordS2;
    logic [31:0] rdData, sp, pc, memAddr;
    logic [2:0] srcSpace, dstSpace, spaceCode;
    logic dbgEn, lowPower, condResult, branchAlt;
    logic condDone, flush, excValid, debugEnter, bkptExec, spaceValid, spLoad, pcLoad, memReq;
    logic ackS1, ackS2, errS1, errS2;
  } state_t;
  state_t s_r, s_nxt;
  // ----------------
  // Helpers
  // ----------------
  function automatic logic condTest(input logic [3:0] code, input logic [15:0] w);
    logic c, v, z, n;
    c = w[FLAG_C];
    v = w[FLAG_V];
    z = w[FLAG_Z];
    n = w[FLAG_N];
    case (code)
      COND_TRUE: condTest = 1'b1;
      COND_FALSE: condTest = 1'b0;
      COND_HIGH: condTest = ~c & ~z;
      COND_LOW_OR_SAME: condTest = c | z;
      COND_CARRY_CLR: condTest = ~c;
      COND_CARRY_SET: condTest = c;
      COND_NOT_EQUAL: condTest = ~z;
      COND_EQUAL: condTest = z;
      COND_OVF_CLR: condTest = ~v;
      COND_OVF_SET: condTest = v;
      COND_PLUS: condTest = ~n;
      COND_MINUS: condTest = n;
      COND_GREATER_EQUAL: condTest = ~(n ^ v);
      COND_LESS_THAN: condTest = n ^ v;
      COND_GREATER_THAN: condTest = ~z & ~(n ^ v);
      default: condTest = z | (n ^ v);
    endcase
  endfunction
  // Sign-extends an operand to 32 bits by its size
  function automatic logic signed [31:0] sizedVal(input logic [31:0] x, input opsize_t sz);
    case (sz)
      SZ_BYTE: sizedVal = {{24{x[7]}}, x[7:0]};
      SZ_WORD: sizedVal = {{16{x[15]}}, x[15:0]};
      default: sizedVal = x;
    endcase
  endfunction
  function automatic logic isPrivileged(input sysop_t k);
    case (k)
      OP_STOP, OP_LP_HALT, OP_PSW_AND, OP_PSW_XOR, OP_PSW_OR, OP_PSW_MOVE_IN,
      OP_ALT_MOVE, OP_EXC_RETURN, OP_PRIV_OTHER: isPrivileged = 1'b1;
      default: isPrivileged = 1'b0;
    endcase
  endfunction
  function automatic logic isFlushing(input sysop_t k);
    case (k)
      OP_BRANCH, OP_SETCOND, OP_DECBRANCH, OP_NONE: isFlushing = 1'b0;
      default: isFlushing = 1'b1;
    endcase
  endfunction
  // ----------------
  // Next state
  // ----------------
  logic take;
  logic signed [31:0] val, lo, hi;
  always_comb begin
    s_nxt = s_r;
    take = opValid && (s_r.fsm == ST_IDLE);
    val = sizedVal(opReq.value, opReq.size);
    lo = sizedVal(opReq.lower, opReq.size);
    hi = sizedVal(opReq.upper, opReq.size);
    // Pin synchronisers; the first stage feeds only the second
    s_nxt.ackS1 = bkptAckPin;
    s_nxt.ackS2 = s_r.ackS1;
    s_nxt.errS1 = bkptErrPin;
    s_nxt.errS2 = s_r.errS1;
    s_nxt.wordS1 = bkptWordPin;
    s_nxt.wordS2 = s_r.wordS1;
    s_nxt.condDone = 1'b0;
    s_nxt.flush = 1'b0;
    s_nxt.excValid = 1'b0;
    s_nxt.debugEnter = 1'b0;
    s_nxt.bkptExec = 1'b0;
    s_nxt.spaceValid = 1'b0;
    s_nxt.spLoad = 1'b0;
    s_nxt.pcLoad = 1'b0;
    s_nxt.memReq = 1'b0;
    s_nxt.rdData = 32'h00000000;
    if (regRd) begin
      if (regAddr == REG_CTRL) begin
        s_nxt.rdData[CTRL_DBG_EN] = s_r.dbgEn;
      end else if (regAddr == REG_SRC_SPACE) begin
        s_nxt.rdData[2:0] = s_r.srcSpace;
      end else if (regAddr == REG_DST_SPACE) begin
        s_nxt.rdData[2:0] = s_r.dstSpace;
      end else if (regAddr == REG_PSW) begin
        s_nxt.rdData[15:0] = s_r.psw;
      end else if (regAddr == REG_STATUS) begin
        s_nxt.rdData = {24'h000000, s_r.lowPower, s_r.lastExc, 1'b0, s_r.fsm};
      end
    end
    if (regWr) begin
      if (regAddr == REG_CTRL) begin
        s_nxt.dbgEn = regWrData[CTRL_DBG_EN];
      end else if (regAddr == REG_SRC_SPACE) begin
        s_nxt.srcSpace = regWrData[2:0];
      end else if (regAddr == REG_DST_SPACE) begin
        s_nxt.dstSpace = regWrData[2:0];
      end
    end
    case (s_r.fsm)
      ST_IDLE: begin
        if (take) begin
          s_nxt.flush = isFlushing(opReq.kind);
          if (isPrivileged(opReq.kind) && !s_r.psw[PSW_SUPER]) begin
            s_nxt.excValid = 1'b1;
            s_nxt.excKind = EXC_PRIVILEGE;
          end else begin
            case (opReq.kind)
              OP_BRANCH, OP_SETCOND, OP_DECBRANCH: begin
                s_nxt.condDone = 1'b1;
                s_nxt.condResult = condTest(opReq.cond, s_r.psw);
                // Branch with the false code is another instruction, never a test
                s_nxt.branchAlt = (opReq.kind == OP_BRANCH) && (opReq.cond == COND_FALSE);
                if (s_nxt.branchAlt) begin
                  s_nxt.condResult = 1'b0;
                end
              end
              OP_COND_TRAP: begin
                s_nxt.condDone = 1'b1;
                s_nxt.condResult = condTest(opReq.cond, s_r.psw);
                s_nxt.branchAlt = 1'b0;
                s_nxt.excValid = s_nxt.condResult;
                s_nxt.excKind = EXC_COND_TRAP;
              end
              OP_OVF_TRAP: begin
                s_nxt.excValid = s_r.psw[FLAG_V];
                s_nxt.excKind = EXC_OVF_TRAP;
              end
              OP_BOUND_TEST: begin
                s_nxt.excValid = (val < 0) || (val > hi);
                s_nxt.excKind = EXC_BOUND;
              end
              OP_DUAL_BOUND: begin
                s_nxt.excValid = (val < lo) || (val > hi);
                s_nxt.excKind = EXC_BOUND;
              end
              OP_BRK_POINT: begin
                s_nxt.fsm = ST_BRK_WAIT;
              end
              OP_DEBUG_ENTRY: begin
                s_nxt.debugEnter = s_r.dbgEn;
                s_nxt.excValid = ~s_r.dbgEn;
                s_nxt.excKind = EXC_DEBUG;
              end
              OP_STOP, OP_LP_HALT: begin
                s_nxt.psw = opReq.imm;
                s_nxt.lowPower = (opReq.kind == OP_LP_HALT);
                s_nxt.fsm = ST_HALT;
              end
              OP_FLAG_AND: s_nxt.psw = s_r.psw & (opReq.imm | ~FLAG_BYTE_MASK);
              OP_FLAG_XOR: s_nxt.psw = s_r.psw ^ (opReq.imm & FLAG_BYTE_MASK);
              OP_FLAG_OR: s_nxt.psw = s_r.psw | (opReq.imm & FLAG_BYTE_MASK);
              OP_FLAG_MOVE_IN: begin
                s_nxt.psw = (s_r.psw & ~FLAG_BYTE_MASK) | (opReq.imm & FLAG_BYTE_MASK);
              end
              OP_PSW_AND: s_nxt.psw = s_r.psw & opReq.imm;
              OP_PSW_XOR: s_nxt.psw = s_r.psw ^ opReq.imm;
              OP_PSW_OR: s_nxt.psw = s_r.psw | opReq.imm;
              OP_PSW_MOVE_IN: s_nxt.psw = opReq.imm;
              OP_ALT_MOVE: begin
                s_nxt.spaceValid = 1'b1;
                s_nxt.spaceCode = opReq.altWrite ? s_r.dstSpace : s_r.srcSpace;
              end
              OP_EXC_RETURN: begin
                s_nxt.sp = stackPtr;
                s_nxt.memReq = 1'b1;
                s_nxt.memAddr = stackPtr;
                s_nxt.fsm = ST_RET_SR;
              end
              default: begin
              end
            endcase
          end
        end
      end
      ST_HALT: begin
        // Only an external wake leaves the halt; the register port stays live
        if (wakeIn) begin
          s_nxt.lowPower = 1'b0;
          s_nxt.fsm = ST_IDLE;
        end
      end
      ST_BRK_WAIT: begin
        // Acknowledge wins if both arrive together
        if (s_r.ackS2) begin
          s_nxt.bkptExec = 1'b1;
          s_nxt.bkptWord = s_r.wordS2;
          s_nxt.fsm = ST_IDLE;
        end else if (s_r.errS2) begin
          s_nxt.excValid = 1'b1;
          s_nxt.excKind = EXC_ILLEGAL;
          s_nxt.fsm = ST_IDLE;
        end
      end
      ST_RET_SR: begin
        if (memAck) begin
          s_nxt.newPsw = memData;
          s_nxt.memReq = 1'b1;
          s_nxt.memAddr = s_r.sp + RET_PC_HI_OFS;
          s_nxt.fsm = ST_RET_PC_HI;
        end
      end
      ST_RET_PC_HI: begin
        if (memAck) begin
          s_nxt.pc[31:16] = memData;
          s_nxt.memReq = 1'b1;
          s_nxt.memAddr = s_r.sp + RET_PC_LO_OFS;
          s_nxt.fsm = ST_RET_PC_LO;
        end
      end
      ST_RET_PC_LO: begin
        if (memAck) begin
          s_nxt.pc[15:0] = memData;
          s_nxt.memReq = 1'b1;
          s_nxt.memAddr = s_r.sp + RET_FMT_OFS;
          s_nxt.fsm = ST_RET_FMT;
        end
      end
      ST_RET_FMT: begin
        if (memAck) begin
          s_nxt.fsm = ST_IDLE;
          // Unknown formats leave the state word untouched and raise neither PC load nor SP load
          if (memData[15:12] == FMT_SHORT || memData[15:12] == FMT_LONG) begin
            s_nxt.psw = s_r.newPsw;
            s_nxt.pcLoad = 1'b1;
            s_nxt.spLoad = 1'b1;
            s_nxt.sp = s_r.sp + ((memData[15:12] == FMT_LONG) ? RET_LONG_LEN : RET_SHORT_LEN);
          end else begin
            s_nxt.excValid = 1'b1;
            s_nxt.excKind = EXC_FORMAT;
          end
        end
      end
      default: s_nxt.fsm = ST_IDLE;
    endcase
    if (s_nxt.excValid) begin
      s_nxt.lastExc = s_nxt.excKind;
    end
  end
  // ----------------
  // Registers
  // ----------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.psw <= PSW_RESET;
      s_r.excKind <= EXC_NONE;
      s_r.lastExc <= EXC_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ----------------
  // Outputs
  // ----------------
  assign opReady = (s_r.fsm == ST_IDLE);
  assign memReq = s_r.memReq;
  assign memAddr = s_r.memAddr;
  assign bkptCycle = (s_r.fsm == ST_BRK_WAIT);
  assign bkptExec = s_r.bkptExec;
  assign bkptWord = s_r.bkptWord;
  assign condDone = s_r.condDone;
  assign condResult = s_r.condResult;
  assign branchAltCode = s_r.branchAlt;
  assign flushPulse = s_r.flush;
  assign excValid = s_r.excValid;
  assign excKind = s_r.excKind;
  assign debugEnter = s_r.debugEnter;
  assign halted = (s_r.fsm == ST_HALT);
  assign lowPower = s_r.lowPower;
  assign spaceValid = s_r.spaceValid;
  assign spaceCode = s_r.spaceCode;
  assign psw = s_r.psw;
  assign spLoad = s_r.spLoad;
  assign spOut = s_r.sp;
  assign pcLoad = s_r.pcLoad;
  assign pcOut = s_r.pc;
  assign regRdData = s_r.rdData;
endmodule // condition_test_sysctl_unit
`default_nettype wire

// >>> tb/cond_sysctl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cond_sysctl_checker
  import cond_sysctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire op_req_t opReq,
  input wire logic opReady,
  input wire logic [31:0] stackPtr,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic wakeIn,
  input wire logic condDone,
  input wire logic condResult,
  input wire logic branchAltCode,
  input wire logic excValid,
  input wire exc_t excKind,
  input wire logic halted,
  input wire logic [15:0] psw
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  sysop_t k;
  assign take = opValid && opReady;
  assign k = opReq.kind;
  a_cond_true: assert property (
    take && k == OP_SETCOND && opReq.cond == COND_TRUE |=> condDone && condResult)
    else $error("true test not true");
  a_cond_false: assert property (
    take && k == OP_SETCOND && opReq.cond == COND_FALSE |=> condDone && !condResult)
    else $error("false test not false");
  a_equal_test: assert property (
    take && k == OP_SETCOND && opReq.cond == COND_EQUAL |=> condResult == $past(psw[FLAG_Z]))
    else $error("equal test wrong");
  a_branch_alt: assert property (
    take && k == OP_BRANCH && opReq.cond == COND_FALSE |=> branchAltCode && !condResult)
    else $error("false branch code not flagged");
  a_ovf_trap: assert property (
    take && k == OP_OVF_TRAP && psw[FLAG_V] |=> excValid && excKind == EXC_OVF_TRAP)
    else $error("overflow trap missing");
  a_priv_refuse: assert property (
    take && k == OP_PSW_OR && !psw[PSW_SUPER] |=> excValid && excKind == EXC_PRIVILEGE
    && psw == $past(psw)) else $error("user state not refused");
  a_stop_load: assert property (
    take && k == OP_STOP && psw[PSW_SUPER] |=> psw == $past(opReq.imm) && halted && !opReady)
    else $error("stop did not load and halt");
  a_wake_release: assert property (
    halted && wakeIn |=> !halted) else $error("wake did not leave halt");
  a_ret_first: assert property (
    take && k == OP_EXC_RETURN && psw[PSW_SUPER] |=> memReq && memAddr == $past(stackPtr))
    else $error("return first read wrong");
  c_setcond: cover property (take && k == OP_SETCOND);
  c_exc: cover property (excValid);
  c_halt: cover property ($rose(halted));
endmodule // cond_sysctl_checker

bind condition_test_sysctl_unit cond_sysctl_checker chk_u (.clk(clk), .rst_n(rst_n),
  .opValid(opValid), .opReq(opReq), .opReady(opReady), .stackPtr(stackPtr),
  .memReq(memReq), .memAddr(memAddr), .wakeIn(wakeIn), .condDone(condDone),
  .condResult(condResult), .branchAltCode(branchAltCode), .excValid(excValid),
  .excKind(excKind), .halted(halted), .psw(psw));
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cond_sysctl_pkg::*;
  // ----------------
  // Signals
  // ----------------
  localparam logic [31:0] NIL = 32'h00000000;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic opValid = 1'h0;
  op_req_t opReq = '0;
  logic [31:0] stackPtr = 32'h00001000;
  logic memAck = 1'h0;
  logic bkptAckPin = 1'h0, bkptErrPin = 1'h0;
  logic wakeIn = 1'h0;
  logic regWr = 1'h0, regRd = 1'h0;
  logic [15:0] memData = 16'h0000;
  logic [15:0] bkptWordPin = 16'hA5C3;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = NIL;
  logic opReady, memReq, bkptCycle, bkptExec, condDone, condResult, branchAltCode;
  logic flushPulse, excValid, debugEnter, halted, lowPower, spaceValid, spLoad, pcLoad;
  logic [31:0] memAddr, spOut, pcOut, regRdData;
  logic [15:0] bkptWord, psw;
  logic [2:0] spaceCode;
  exc_t excKind;
  int errors = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  condition_test_sysctl_unit dut_u (.clk(clk), .rst_n(rst_n), .opValid(opValid),
    .opReq(opReq), .opReady(opReady), .stackPtr(stackPtr), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .memData(memData), .bkptCycle(bkptCycle),
    .bkptAckPin(bkptAckPin), .bkptErrPin(bkptErrPin), .bkptWordPin(bkptWordPin),
    .bkptExec(bkptExec), .bkptWord(bkptWord), .wakeIn(wakeIn), .condDone(condDone),
    .condResult(condResult), .branchAltCode(branchAltCode), .flushPulse(flushPulse),
    .excValid(excValid), .excKind(excKind), .debugEnter(debugEnter), .halted(halted),
    .lowPower(lowPower), .spaceValid(spaceValid), .spaceCode(spaceCode), .psw(psw),
    .spLoad(spLoad), .spOut(spOut), .pcLoad(pcLoad), .pcOut(pcOut), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Bounded wait; a pulse up at entry counts
  task automatic waitHi(ref logic s, input string nm);
    int i;
    for (i = 0; i < 50 && s !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    if (s !== 1'h1) begin
      chk(nm, NIL, 32'h1);
      test_done();
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (20) @(posedge clk);
    #1;
    chk("reset psw", 32'(psw), 32'(PSW_RESET));
    @(posedge clk);
    rst_n <= 1'h1;
  endtask
  task automatic op(input sysop_t k, input logic [3:0] c, input logic [15:0] im,
      input logic [31:0] v = NIL, input logic [31:0] lo = NIL, input logic [31:0] up = NIL,
      input logic alt = 1'h0);
    logic nf;
    nf = !(k inside {OP_BRANCH, OP_SETCOND, OP_DECBRANCH});
    @(posedge clk);
    opValid <= 1'h1;
    opReq <= '{kind: k, cond: c, imm: im, value: v, lower: lo, upper: up,
      size: SZ_LONG, altWrite: alt};
    @(posedge clk);
    opValid <= 1'h0;
    #1;
    chk("flush", 32'(flushPulse), 32'(nf));
  endtask
  task automatic tx(input sysop_t k, input logic [31:0] v, input logic [31:0] lo,
      input logic [31:0] up, input logic e, input exc_t ek);
    op(k, COND_EQUAL, 16'h0000, v, lo, up);
    chk("exc valid", 32'(excValid), 32'(e));
    if (e) begin
      chk("exc kind", 32'(excKind), 32'(ek));
    end
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic regRead(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1;
    chk("reg read", regRdData, e);
  endtask
  function automatic logic condExp(input logic [3:0] c, input logic [3:0] f);
    logic cf, v, z, n;
    cf = f[FLAG_C];
    v = f[FLAG_V];
    z = f[FLAG_Z];
    n = f[FLAG_N];
    case (c)
      COND_TRUE: return 1'h1;
      COND_FALSE: return 1'h0;
      COND_HIGH: return !cf && !z;
      COND_LOW_OR_SAME: return cf || z;
      COND_CARRY_CLR: return !cf;
      COND_CARRY_SET: return cf;
      COND_NOT_EQUAL: return !z;
      COND_EQUAL: return z;
      COND_OVF_CLR: return !v;
      COND_OVF_SET: return v;
      COND_PLUS: return !n;
      COND_MINUS: return n;
      COND_GREATER_EQUAL: return n == v;
      COND_LESS_THAN: return n != v;
      COND_GREATER_THAN: return !z && n == v;
      default: return z || n != v;
    endcase
  endfunction
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_cond();
    logic [4:0] f, c;
    for (f = 5'h00; f < 5'h10; f++) begin
      op(OP_FLAG_AND, 4'h0, 16'h0000);
      op(OP_FLAG_OR, 4'h0, {12'h000, f[3:0]});
      chk("flag or", 32'(psw), 32'(PSW_RESET) | 32'(f[3:0]));
      for (c = 5'h00; c < 5'h10; c++) begin
        op(OP_SETCOND, c[3:0], 16'h0000);
        chk("cond done", 32'(condDone), 32'h1);
        chk("cond result", 32'(condResult), 32'(condExp(c[3:0], f[3:0])));
      end
    end
    op(OP_FLAG_XOR, 4'h0, 16'hFF0A);
    chk("flag xor", 32'(psw), 32'h00002705);
    op(OP_FLAG_AND, 4'h0, 16'h0003);
    chk("flag and", 32'(psw), 32'h00002701);
    op(OP_BRANCH, COND_FALSE, 16'h0000);
    chk("alt code", 32'(branchAltCode), 32'h1);
    chk("alt result", 32'(condResult), NIL);
    op(OP_BRANCH, COND_TRUE, 16'h0000);
    chk("alt code", 32'(branchAltCode), NIL);
    $display("test cond done");
  endtask
  task automatic t_traps();
    op(OP_FLAG_AND, 4'h0, 16'h0000);
    op(OP_FLAG_OR, 4'h0, 16'h0006);
    tx(OP_COND_TRAP, NIL, NIL, NIL, 1'h1, EXC_COND_TRAP);
    tx(OP_OVF_TRAP, NIL, NIL, NIL, 1'h1, EXC_OVF_TRAP);
    op(OP_COND_TRAP, COND_NOT_EQUAL, 16'h0000);
    chk("no trap", 32'(excValid), NIL);
    op(OP_FLAG_AND, 4'h0, 16'h0000);
    tx(OP_OVF_TRAP, NIL, NIL, NIL, 1'h0, EXC_NONE);
    tx(OP_DUAL_BOUND, 32'h5, 32'hA, 32'h14, 1'h1, EXC_BOUND);
    tx(OP_DUAL_BOUND, 32'h14, 32'hA, 32'h14, 1'h0, EXC_NONE);
    tx(OP_DUAL_BOUND, 32'h15, 32'hA, 32'h14, 1'h1, EXC_BOUND);
    tx(OP_BOUND_TEST, 32'hFFFFFFFF, NIL, 32'h64, 1'h1, EXC_BOUND);
    tx(OP_BOUND_TEST, 32'h64, NIL, 32'h64, 1'h0, EXC_NONE);
    tx(OP_BOUND_TEST, 32'h65, NIL, 32'h64, 1'h1, EXC_BOUND);
    $display("test traps done");
  endtask
  task automatic t_halt(input sysop_t k, input logic [15:0] im);
    op(k, 4'h0, im);
    chk("halt psw", 32'(psw), 32'(im));
    chk("halted", 32'(halted), 32'h1);
    chk("ready", 32'(opReady), NIL);
    chk("low power", 32'(lowPower), 32'(k == OP_LP_HALT));
    @(posedge clk);
    wakeIn <= 1'h1;
    @(posedge clk);
    wakeIn <= 1'h0;
    #1;
    chk("woken", 32'(halted), NIL);
    $display("test halt done");
  endtask
  task automatic t_ret();
    logic [15:0] w [4];
    int i;
    w = '{16'h2015, 16'h0001, 16'h2340, 16'h0000};
    op(OP_EXC_RETURN, 4'h0, 16'h0000);
    for (i = 0; i < 4; i++) begin
      waitHi(memReq, "mem request");
      chk("mem addr", memAddr, stackPtr + 32'(i) * 32'h2);
      @(posedge clk);
      memAck <= 1'h1;
      memData <= w[i];
      @(posedge clk);
      memAck <= 1'h0;
      // Released bus shows the inverse, not a stale word
      memData <= ~w[i];
      #1;
    end
    waitHi(pcLoad, "pc load");
    chk("sp load", 32'(spLoad), 32'h1);
    chk("ret psw", 32'(psw), 32'h00002015);
    chk("ret pc", pcOut, 32'h00012340);
    chk("ret sp", spOut, 32'h00001008);
    $display("test return done");
  endtask
  task automatic t_breakpoint_op();
    op(OP_BRK_POINT, 4'h0, 16'h0000);
    chk("breakpoint_op cycle", 32'(bkptCycle), 32'h1);
    bkptAckPin <= 1'h1;
    waitHi(bkptExec, "breakpoint_op exec");
    chk("breakpoint_op word", 32'(bkptWord), 32'h0000A5C3);
    bkptAckPin <= 1'h0;
    repeat (4) @(posedge clk);
    op(OP_BRK_POINT, 4'h0, 16'h0000);
    bkptErrPin <= 1'h1;
    waitHi(excValid, "breakpoint_op error");
    chk("breakpoint_op illegal", 32'(excKind), 32'(EXC_ILLEGAL));
    bkptErrPin <= 1'h0;
    repeat (4) @(posedge clk);
    $display("test breakpoint done");
  endtask
  task automatic t_psw();
    op(OP_PSW_AND, 4'h0, 16'hFF00);
    chk("psw and", 32'(psw), 32'h00002000);
    op(OP_PSW_OR, 4'h0, 16'h0011);
    chk("psw or", 32'(psw), 32'h00002011);
    op(OP_PSW_XOR, 4'h0, 16'h0300);
    chk("psw xor", 32'(psw), 32'h00002311);
    op(OP_PSW_AND, 4'h0, 16'hDFFF);
    op(OP_PSW_OR, 4'h0, 16'h0400);
    chk("priv exc", 32'(excKind), 32'(EXC_PRIVILEGE));
    chk("priv psw", 32'(psw), 32'h00000311);
    $display("test state word done");
  endtask
  task automatic t_regs();
    regWrite(REG_SRC_SPACE, 32'h3);
    regWrite(REG_DST_SPACE, 32'h5);
    regRead(REG_SRC_SPACE, 32'h3);
    regWrite(4'hF, 32'hFFFFFFFF);
    regRead(4'hF, NIL);
    regRead(REG_PSW, 32'h00002700);
    op(OP_ALT_MOVE, 4'h0, 16'h0000, NIL, NIL, NIL, 1'h1);
    chk("space write", {28'h0, spaceValid, spaceCode}, 32'hD);
    op(OP_ALT_MOVE, 4'h0, 16'h0000, NIL, NIL, NIL, 1'h0);
    chk("space read", {28'h0, spaceValid, spaceCode}, 32'hB);
    regWrite(REG_CTRL, 32'h1);
    regRead(REG_CTRL, 32'h1);
    op(OP_DEBUG_ENTRY, 4'h0, 16'h0000);
    chk("debug on", {30'h0, debugEnter, excValid}, 32'h2);
    regWrite(REG_CTRL, NIL);
    tx(OP_DEBUG_ENTRY, NIL, NIL, NIL, 1'h1, EXC_DEBUG);
    regRead(REG_STATUS, 32'(EXC_DEBUG) << 4);
    $display("test registers done");
  endtask
  initial begin
    do_reset();
    t_cond();
    t_traps();
    t_halt(OP_STOP, 16'h2715);
    t_halt(OP_LP_HALT, 16'h2704);
    t_ret();
    t_breakpoint_op();
    t_psw();
    do_reset();
    t_regs();
    test_done();
  end
  // Hang guard above the longest run
  initial begin
    repeat (32'h000186A0) @(posedge clk);
    chk("run time", NIL, 32'h1);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
